// ---- core/rte_bit_timer.sv ----
// character timer: counts a number of bit times, each a fixed count of clock cycles
`timescale 1ns/1ps
module rte_bit_timer #(
   parameter int unsigned W = 16
) (
   input  wire logic         i_ref_clk,   // system clock
   input  wire logic         i_rst_n,     // async reset, active low
   input  wire logic         i_start,     // restart a character
   input  wire logic         i_abort,     // stop counting at once
   input  wire logic [W-1:0] i_bit_cyc,   // cycles per bit
   input  wire logic [3:0]   i_nbits,     // bits per character
   output logic              o_busy,      // character in progress
   output logic              o_last_bit,  // final bit of the character
   output logic              o_bit_tick,  // one-cycle pulse at each bit end
   output logic              o_done       // one-cycle pulse at character end
);

   logic [W-1:0] cyc_reg;
   logic [W-1:0] bit_cyc_reg;
   logic [3:0]   bits_reg;
   logic         busy_reg;

   if (W < 2)
   begin
      $error("rte_bit_timer: W too small");
   end

   // start wins over the running count so back-to-back characters chain cleanly
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cyc_reg     <= '0;
         bit_cyc_reg <= '0;
         bits_reg    <= 4'h0;
         busy_reg    <= 1'b0;
      end
      else if (i_abort)
      begin
         busy_reg <= 1'b0;
      end
      else if (i_start)
      begin
         bit_cyc_reg <= i_bit_cyc;
         cyc_reg     <= i_bit_cyc - 1'b1;
         bits_reg    <= i_nbits - 4'h1;
         busy_reg    <= 1'b1;
      end
      else if (busy_reg)
      begin
         if (cyc_reg == '0)
         begin
            if (bits_reg == 4'h0)
               busy_reg <= 1'b0;
            else
            begin
               bits_reg <= bits_reg - 4'h1;
               cyc_reg  <= bit_cyc_reg - 1'b1;
            end
         end
         else
            cyc_reg <= cyc_reg - 1'b1;
      end
   end

   assign o_busy     = busy_reg;
   assign o_last_bit = busy_reg && (bits_reg == 4'h0);
   assign o_bit_tick = busy_reg && !i_start && !i_abort && (cyc_reg == '0);
   assign o_done     = o_bit_tick && (bits_reg == 4'h0);

endmodule

// ---- core/rte_pkg.sv ----
// constants shared by the rs485 automatic transmit-enable block
package rte_pkg;

   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 8;

   localparam logic [ADDR_W-1:0] LINE_MODE_ADDR   = 32'h22C0_0000;
   localparam logic [ADDR_W-1:0] LONG_FRAME_ADDR  = 32'h2300_0000;
   localparam logic [ADDR_W-1:0] BOARD_STAT_ADDR  = 32'h2240_0000;

   localparam logic [DATA_W-1:0] LINE_MODE_RST    = 8'h00;
   localparam logic [DATA_W-1:0] LONG_FRAME_RST   = 8'h00;

   // line mode codes
   localparam logic [2:0] MODE_RS232   = 3'h0;
   localparam logic [2:0] MODE_FULL    = 3'h1;
   localparam logic [2:0] MODE_HALF_96 = 3'h4;
   localparam logic [2:0] MODE_HALF_19 = 3'h5;
   localparam logic [2:0] MODE_HALF_57 = 3'h6;
   localparam logic [2:0] MODE_HALF_115 = 3'h7;

   // field positions
   localparam int unsigned MODE_LSB        = 0;
   localparam int unsigned MODE_MSB        = 2;
   localparam int unsigned LONG_FRAME_BIT  = 0;
   localparam int unsigned STAT_DRIVE_BIT  = 0;
   localparam int unsigned STAT_FITTED_BIT = 1;

   // character lengths in bit times: start + 8 data + stop, one more for parity or second stop
   localparam logic [3:0] CHAR_BITS_STD  = 4'hA;
   localparam logic [3:0] CHAR_BITS_LONG = 4'hB;

   localparam int unsigned CLK_HZ     = 100_000_000;
   localparam int unsigned BAUD_9600  = 9600;
   localparam int unsigned BAUD_19200 = 19200;
   localparam int unsigned BAUD_57600 = 57600;
   localparam int unsigned BAUD_115200 = 115200;

   // bit times in clock cycles, rounded up so the enable never drops early
   localparam int unsigned BIT_CYC_9600   = (CLK_HZ + BAUD_9600 - 1) / BAUD_9600;
   localparam int unsigned BIT_CYC_19200  = (CLK_HZ + BAUD_19200 - 1) / BAUD_19200;
   localparam int unsigned BIT_CYC_57600  = (CLK_HZ + BAUD_57600 - 1) / BAUD_57600;
   localparam int unsigned BIT_CYC_115200 = (CLK_HZ + BAUD_115200 - 1) / BAUD_115200;

   localparam int unsigned CYC_W = 16;

   typedef enum logic [1:0] {
      RTE_LINE_RS232,
      RTE_LINE_FULL,
      RTE_LINE_HALF
   } rte_line_t;

   typedef enum logic {
      RTE_IDLE,
      RTE_DRIVE
   } rte_state_t;

endpackage

// ---- core/rte_top.sv ----
// mode control and automatic transmit enable for the second serial port
//
// Behaviour
// - half duplex transmit enable switched by hardware
// - driver on while sending, receiver after end
// - line mode register resets to RS-232
// - mode one keeps driver always on
// - four to seven half duplex; two, three reserved
// - half duplex codes map to four baud rates
// - long frame register adds one bit time
// - status bit one shows option fitted
`timescale 1ns/1ps
module rte_top
   import rte_pkg::*;
#(
   parameter int unsigned P_BIT_CYC_9600   = rte_pkg::BIT_CYC_9600,
   parameter int unsigned P_BIT_CYC_19200  = rte_pkg::BIT_CYC_19200,
   parameter int unsigned P_BIT_CYC_57600  = rte_pkg::BIT_CYC_57600,
   parameter int unsigned P_BIT_CYC_115200 = rte_pkg::BIT_CYC_115200
) (
   input  wire logic                       i_ref_clk,      // system clock, 100 MHz
   input  wire logic                       i_rst_n,        // async reset, active low
   input  wire logic [rte_pkg::ADDR_W-1:0] i_addr,         // register address
   input  wire logic [rte_pkg::DATA_W-1:0] i_wr_data,      // register write data
   input  wire logic                       i_wr,           // write strobe
   input  wire logic                       i_rd,           // read strobe
   output logic      [rte_pkg::DATA_W-1:0] o_rd_data,      // read data, cycle after strobe
   input  wire logic                       i_opt_fitted,   // rs485 option fitted strap
   input  wire logic                       i_uart_txd,     // serial data from uart transmitter
   output logic                            o_line_txd,     // serial data to the transceiver
   output logic                            o_drv_en,       // transceiver driver enable
   output logic                            o_rcv_en_n,     // transceiver receiver enable, low active
   output logic                            o_rs232_sel     // route port to the rs232 pins
);

   localparam int unsigned MAX_CYC = (1 << CYC_W) - 1;

   // bit times must fit the timer counter, refused at elaboration
   if (P_BIT_CYC_9600 < 1 || P_BIT_CYC_9600 > MAX_CYC)
   begin
      $error("rte_top: P_BIT_CYC_9600 out of range");
   end

   if (P_BIT_CYC_19200 < 1 || P_BIT_CYC_19200 > MAX_CYC)
   begin
      $error("rte_top: P_BIT_CYC_19200 out of range");
   end

   if (P_BIT_CYC_57600 < 1 || P_BIT_CYC_57600 > MAX_CYC)
   begin
      $error("rte_top: P_BIT_CYC_57600 out of range");
   end

   if (P_BIT_CYC_115200 < 1 || P_BIT_CYC_115200 > MAX_CYC)
   begin
      $error("rte_top: P_BIT_CYC_115200 out of range");
   end

   localparam logic [CYC_W-1:0] CYC_96  = CYC_W'(P_BIT_CYC_9600);
   localparam logic [CYC_W-1:0] CYC_19  = CYC_W'(P_BIT_CYC_19200);
   localparam logic [CYC_W-1:0] CYC_57  = CYC_W'(P_BIT_CYC_57600);
   localparam logic [CYC_W-1:0] CYC_115 = CYC_W'(P_BIT_CYC_115200);

   // decode of the three mode bits; reserved codes fall back to the quiet rs232 setting
   function automatic rte_line_t line_of(input logic [2:0] code);
      rte_line_t l;
      l = RTE_LINE_RS232;
      if (code == MODE_FULL)
         l = RTE_LINE_FULL;
      else if (code[2])
         l = RTE_LINE_HALF;
      return l;
   endfunction

   // exact match of the full byte address, so no alias can reach the mode bits
   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] want);
      return (a == want);
   endfunction

   // status word: option strap in bit one, live driver state in bit zero
   function automatic logic [DATA_W-1:0] status_word(input logic fitted, input logic drive);
      logic [DATA_W-1:0] w;
      w                  = '0;
      w[STAT_FITTED_BIT] = fitted;
      w[STAT_DRIVE_BIT]  = drive;
      return w;
   endfunction

   logic [DATA_W-1:0] line_mode_reg;
   logic [DATA_W-1:0] long_frame_reg;
   logic              fitted_reg;
   logic [DATA_W-1:0] rd_data_reg;
   logic [DATA_W-1:0] rd_data_next;
   logic              txd_d_reg;
   logic              line_txd_reg;
   logic              drv_en_reg;
   logic              drv_en_next;
   logic              rcv_en_n_reg;
   logic              rs232_sel_reg;
   rte_state_t        state_reg;
   rte_state_t        state_next;

   logic [2:0]        mode_code;
   rte_line_t         line_mode;
   logic              half_mode;
   logic [CYC_W-1:0]  bit_cyc;
   logic [3:0]        char_bits;
   logic              txd_fall;
   logic              char_start;
   logic              t_busy;
   logic              t_last_bit;
   logic              t_done;
   logic              abort;

   assign mode_code = line_mode_reg[MODE_MSB:MODE_LSB];
   assign line_mode = line_of(mode_code);
   assign half_mode = (line_mode == RTE_LINE_HALF);

   // register writes; software is expected to set these once before traffic starts
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         line_mode_reg <= LINE_MODE_RST;
      else if (i_wr && addr_is(i_addr, LINE_MODE_ADDR))
         line_mode_reg <= i_wr_data;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         long_frame_reg <= LONG_FRAME_RST;
      else if (i_wr && addr_is(i_addr, LONG_FRAME_ADDR))
         long_frame_reg <= i_wr_data;
   end

   // strap is caught by a clocked flop, never by the reset itself
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         fitted_reg <= 1'b0;
      else
         fitted_reg <= i_opt_fitted;
   end

   // read data stand only in the cycle after the strobe; unmapped reads give zero
   always_comb
   begin
      rd_data_next = '0;
      if (i_rd)
      begin
         unique case (i_addr)
            LINE_MODE_ADDR:
               rd_data_next = line_mode_reg;
            LONG_FRAME_ADDR:
               rd_data_next = long_frame_reg;
            BOARD_STAT_ADDR:
               rd_data_next = status_word(fitted_reg, drv_en_reg);
            default:
               rd_data_next = '0;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rd_data_reg <= '0;
      else
         rd_data_reg <= rd_data_next;
   end

   // baud rate and character length chosen by the two mode registers
   always_comb
   begin
      bit_cyc = CYC_115;
      unique case (mode_code)
         MODE_HALF_96:
            bit_cyc = CYC_96;
         MODE_HALF_19:
            bit_cyc = CYC_19;
         MODE_HALF_57:
            bit_cyc = CYC_57;
         default:
            bit_cyc = CYC_115;
      endcase
   end

   assign char_bits = long_frame_reg[LONG_FRAME_BIT] ? CHAR_BITS_LONG : CHAR_BITS_STD;

   // start bit seen as a falling txd; inside a character only the stop bit may
   // carry the next start, so data bits never restart the count
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         txd_d_reg <= 1'b1;
      else
         txd_d_reg <= i_uart_txd;
   end

   assign txd_fall   = txd_d_reg && !i_uart_txd;
   assign char_start = half_mode && txd_fall && (!t_busy || t_last_bit);
   assign abort      = !half_mode;

   // leaving half duplex aborts a character so the pair is freed at once
   rte_bit_timer #(
      .W (CYC_W)
   ) u_timer (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (i_rst_n),
      .i_start    (char_start),
      .i_abort    (abort),
      .i_bit_cyc  (bit_cyc),
      .i_nbits    (char_bits),
      .o_busy     (t_busy),
      .o_last_bit (t_last_bit),
      .o_bit_tick (),
      .o_done     (t_done)
   );

   // half duplex drive state
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         RTE_IDLE:
            if (char_start)
               state_next = RTE_DRIVE;
         RTE_DRIVE:
            if (abort)
               state_next = RTE_IDLE;
            else if (t_done && !char_start)
               state_next = RTE_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state_reg <= RTE_IDLE;
      else
         state_reg <= state_next;
   end

   // full duplex keeps the driver on; rs232 and reserved codes leave it off
   always_comb
   begin
      drv_en_next = 1'b0;
      unique case (line_mode)
         RTE_LINE_FULL:
            drv_en_next = 1'b1;
         RTE_LINE_HALF:
            drv_en_next = (state_next == RTE_DRIVE);
         default:
            drv_en_next = 1'b0;
      endcase
   end

   // data and enable are both one flop behind txd so they stay aligned on the line
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         drv_en_reg <= 1'b0;
      else
         drv_en_reg <= drv_en_next;
   end

   // receiver is parked in rs232 mode and while a half duplex driver owns the pair
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rcv_en_n_reg <= 1'b1;
      else
         rcv_en_n_reg <= (line_mode == RTE_LINE_RS232) || (half_mode && drv_en_next);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         line_txd_reg <= 1'b1;
      else
         line_txd_reg <= i_uart_txd;
   end

   // routing follows the decoded mode, so reserved codes land on rs232 too
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rs232_sel_reg <= 1'b1;
      else
         rs232_sel_reg <= (line_mode == RTE_LINE_RS232);
   end

   assign o_rd_data   = rd_data_reg;
   assign o_line_txd  = line_txd_reg;
   assign o_drv_en    = drv_en_reg;
   assign o_rcv_en_n  = rcv_en_n_reg;
   assign o_rs232_sel = rs232_sel_reg;

endmodule

// ---- test/rte_monitor.sv ----
// port assertions for the rs485 transmit-enable block
`timescale 1ns/1ps
module rte_monitor
   import rte_pkg::*;
#(
   parameter int unsigned P_BIT_CYC_9600   = 20,
   parameter int unsigned P_BIT_CYC_19200  = 10,
   parameter int unsigned P_BIT_CYC_57600  = 6,
   parameter int unsigned P_BIT_CYC_115200 = 4
) (
   input wire logic              i_ref_clk,    // clock
   input wire logic              i_rst_n,      // reset
   input wire logic [ADDR_W-1:0] i_addr,       // address
   input wire logic [DATA_W-1:0] i_wr_data,    // write data
   input wire logic              i_wr,         // write strobe
   input wire logic              i_rd,         // read strobe
   input wire logic [DATA_W-1:0] o_rd_data,    // read data
   input wire logic              i_opt_fitted, // strap
   input wire logic              i_uart_txd,   // uart data
   input wire logic              o_line_txd,   // line data
   input wire logic              o_drv_en,     // driver enable
   input wire logic              o_rcv_en_n,   // receiver enable
   input wire logic              o_rs232_sel   // rs232 route
);
   logic [7:0]  mode_q;
   logic        lf_q;
   logic        txd_q;
   int unsigned bc;
   int unsigned len;
   int unsigned cnt;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   always_comb
   begin
      bc = mode_q[1] ? (mode_q[0] ? P_BIT_CYC_115200 : P_BIT_CYC_57600)
                     : (mode_q[0] ? P_BIT_CYC_19200 : P_BIT_CYC_9600);
      len = (lf_q ? 11 : 10) * bc;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         mode_q <= 8'h00;
         lf_q <= 1'b0;
         txd_q <= 1'b1;
      end
      else
      begin
         if (i_wr && i_addr == LINE_MODE_ADDR)
            mode_q <= i_wr_data;
         if (i_wr && i_addr == LONG_FRAME_ADDR)
            lf_q <= i_wr_data[0];
         txd_q <= i_uart_txd;
      end

   // data bits also fall, so only a fall when idle or in the last bit restarts the count
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         cnt <= 0;
      else if (!mode_q[2] || (txd_q && !i_uart_txd && (!o_drv_en || cnt >= len - bc)))
         cnt <= 0;
      else if (o_drv_en)
         cnt <= cnt + 1;

   rs232_state_a: assert property (!mode_q[2] && mode_q[1:0] != 2'b01
      |=> o_rs232_sel && !o_drv_en && o_rcv_en_n) else $error("rs232 outputs wrong");
   full_duplex_a: assert property (mode_q[2:0] == 3'h1
      |=> o_drv_en && !o_rcv_en_n && !o_rs232_sel) else $error("full duplex outputs wrong");
   half_pair_a: assert property (mode_q[2]
      |=> !o_rs232_sel && o_rcv_en_n == o_drv_en) else $error("half duplex enables disagree");
   start_drive_a: assert property (mode_q[2] && txd_q && !i_uart_txd && !o_drv_en
      |=> o_drv_en && o_rcv_en_n && !o_line_txd) else $error("driver not on at start bit");
   hold_len_a: assert property (mode_q[2] && $fell(o_drv_en) && $stable(mode_q)
      |-> cnt == len) else $error("enable length wrong");
   hold_max_a: assert property (mode_q[2] && o_drv_en |-> cnt < len) else $error("enable held too long");
   mode_read_a: assert property (i_rd && i_addr == LINE_MODE_ADDR
      |=> o_rd_data == $past(mode_q)) else $error("mode readback wrong");
   status_read_a: assert property (i_rd && i_addr == BOARD_STAT_ADDR
      |=> o_rd_data == {6'h00, $past(i_opt_fitted, 2), $past(o_drv_en)}) else $error("status readback wrong");

   cover property (mode_q[2] && $fell(o_drv_en));
   cover property (mode_q[2:0] == 3'h1 && o_drv_en);
   cover property (i_rd && i_addr == BOARD_STAT_ADDR);
endmodule

bind rte_top rte_monitor #(.P_BIT_CYC_9600(P_BIT_CYC_9600), .P_BIT_CYC_19200(P_BIT_CYC_19200),
   .P_BIT_CYC_57600(P_BIT_CYC_57600), .P_BIT_CYC_115200(P_BIT_CYC_115200)) u_rte_monitor (.i_ref_clk,
   .i_rst_n, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_opt_fitted, .i_uart_txd, .o_line_txd,
   .o_drv_en, .o_rcv_en_n, .o_rs232_sel);

// ---- test/rte_top_tb.sv ----
// self-checking bench for the rs485 transmit-enable block
`timescale 1ns/1ps
module rte_top_tb;
   import rte_pkg::*;
   localparam int unsigned BC [4] = '{20, 10, 6, 4};
   logic              i_ref_clk = 1'b0;
   logic              i_rst_n = 1'b0;
   logic [ADDR_W-1:0] i_addr = 32'h0000_0000;
   logic [DATA_W-1:0] i_wr_data = 8'h00;
   logic              i_wr = 1'b0;
   logic              i_rd = 1'b0;
   logic              i_opt_fitted = 1'b1;
   logic [DATA_W-1:0] o_rd_data;
   logic              i_uart_txd;
   logic              o_line_txd;
   logic              o_drv_en;
   logic              o_rcv_en_n;
   logic              o_rs232_sel;
   logic              send = 1'b0;
   logic [7:0]        data = 8'h00;
   logic              lf = 1'b0;
   logic [15:0]       bitc = 16'h0014;
   logic              take;
   int                error_cnt = 0;
   int                check_count = 0;

   always #5 i_ref_clk = ~i_ref_clk;

   rte_top #(.P_BIT_CYC_9600(20), .P_BIT_CYC_19200(10), .P_BIT_CYC_57600(6), .P_BIT_CYC_115200(4)) u_rte_top (
      .i_ref_clk, .i_rst_n, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_opt_fitted, .i_uart_txd,
      .o_line_txd, .o_drv_en, .o_rcv_en_n, .o_rs232_sel);
   rte_uart_model u_rte_uart_model (.i_ref_clk, .i_rst_n, .i_send(send), .i_byte(data), .i_long(lf),
      .i_bit_cyc(bitc), .o_take(take), .o_txd(i_uart_txd));

   task end_of_test;
      if (error_cnt == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wr_data <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask

   task rdc(input logic [31:0] a, input logic [7:0] exp);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      check(o_rd_data, exp);
   endtask

   task tx(input logic [7:0] b);
      @(posedge i_ref_clk);
      send <= 1'b1;
      data <= b;
      for (int k = 0; k < 600; k++)
      begin
         @(negedge i_ref_clk);
         if (take === 1'b1)
         begin
            @(posedge i_ref_clk);
            send <= 1'b0;
            return;
         end
      end
      error_cnt++;
      end_of_test();
   endtask

   // counts the cycles the driver stays on, ending at the first drop
   task measure(output int n);
      n = 0;
      for (int k = 0; k < 2000; k++)
      begin
         @(posedge i_ref_clk);
         #1;
         if (o_drv_en === 1'b1)
            n++;
         else if (n > 0)
            return;
      end
      error_cnt++;
      end_of_test();
   endtask

   initial
   begin
      int n;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      rdc(LINE_MODE_ADDR, LINE_MODE_RST);
      rdc(LONG_FRAME_ADDR, LONG_FRAME_RST);
      rdc(BOARD_STAT_ADDR, 8'h02);
      wr(BOARD_STAT_ADDR, 8'hFF);
      rdc(BOARD_STAT_ADDR, 8'h02);
      rdc(32'h22C0_0004, 8'h00);
      for (int m = 0; m < 8; m++)
      begin
         wr(LINE_MODE_ADDR, 8'(m));
         rdc(LINE_MODE_ADDR, 8'(m));
         check({o_rs232_sel, o_drv_en, o_rcv_en_n}, m == 1 ? 3'b010 : (m >= 4 ? 3'b000 : 3'b101));
      end
      for (int l = 0; l < 2; l++)
         for (int m = 4; m < 8; m++)
         begin
            wr(LONG_FRAME_ADDR, 8'(l));
            wr(LINE_MODE_ADDR, 8'(m));
            lf <= l[0];
            bitc <= 16'(BC[m-4]);
            fork
               tx(8'h5A);
               measure(n);
            join
            check(n, (10 + l) * BC[m-4]);
         end
      rdc(LONG_FRAME_ADDR, 8'h01);
      fork
         begin
            tx(8'h5A);
            tx(8'hA5);
         end
         measure(n);
      join
      check(n, 2 * 11 * 4);
      // leaving half duplex mid-character must release the line at once
      wr(LINE_MODE_ADDR, 8'h04);
      bitc <= 16'h0014;
      tx(8'h00);
      repeat (5) @(posedge i_ref_clk);
      #1;
      check({o_drv_en, o_rcv_en_n, o_line_txd}, 3'b110);
      rdc(BOARD_STAT_ADDR, 8'h03);
      wr(LINE_MODE_ADDR, 8'h00);
      @(posedge i_ref_clk);
      #1;
      check({o_rs232_sel, o_drv_en}, 2'b10);
      repeat (300) @(posedge i_ref_clk);
      end_of_test();
   end
endmodule

// ---- test/rte_uart_model.sv ----
// behavioural uart transmit path feeding characters into the block
`timescale 1ns/1ps
module rte_uart_model (
   input  wire logic        i_ref_clk, // clock
   input  wire logic        i_rst_n,   // reset
   input  wire logic        i_send,    // character offered
   input  wire logic [7:0]  i_byte,    // character
   input  wire logic        i_long,    // parity bit added
   input  wire logic [15:0] i_bit_cyc, // cycles per bit
   output logic             o_take,    // taken at this edge
   output logic             o_txd      // serial data, idle high
);
   logic [10:0] sh;
   logic [3:0]  bits;
   logic [15:0] cyc;

   // a queued character follows the stop bit with no gap
   assign o_take = i_send && (bits == 4'h0 || (bits == 4'h1 && cyc + 16'h1 >= i_bit_cyc));
   assign o_txd = (bits == 4'h0) ? 1'b1 : sh[0];

   always @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         bits <= 4'h0;
         cyc <= 16'h0;
         sh <= 11'h7FF;
      end
      else if (bits != 4'h0 && cyc + 16'h1 < i_bit_cyc)
         cyc <= cyc + 16'h1;
      else
      begin
         cyc <= 16'h0;
         if (bits > 4'h1)
         begin
            sh <= sh >> 1;
            bits <= bits - 4'h1;
         end
         else if (i_send)
         begin
            sh <= i_long ? {1'b1, ^i_byte, i_byte, 1'b0} : {2'b11, i_byte, 1'b0};
            bits <= i_long ? 4'hB : 4'hA;
         end
         else
            bits <= 4'h0;
      end
endmodule
